// File: src/sbt_tap.sv
// Contract
// - the sixteen-state controller is forced to its reset state at power-up, no test reset pin.
// - memory array contents are never shifted out, only pad states and test registers.
// - an undriven mode-select or serial data input behaves as logic one.
// - instruction register is 3 bits, bypass 1 bit, identification 32 bits, boundary chain 107 bits.
// - code 000 selects the external test, data pins off, chain captures inputs and feeds serial out.
// - code 010 selects sample with outputs off, data pins off, chain samples and feeds serial out.
// - code 100 selects sample, chain feeds serial out, data pin drive untouched.
// - code 001 selects the identification register, serial in entering its top bit 31.
// - codes 011, 110 and 111 select bypass and the bypass bit clears when one takes effect.
// - leaving data shift under bypass, the bypass bit keeps the last bit shifted in.
// - identification holds revision 31:28, part 27:18, vendor 17:12, maker 11:1, bit 0 one.
// - serial out changes only after a falling test clock edge.
module sbt_tap #(
  parameter logic [3:0] ID_REV = 4'h2,        // arbitrary value
  parameter logic [9:0] ID_PART = 10'h155,    // arbitrary value
  parameter logic [5:0] ID_VEND = 6'h0a,      // arbitrary value
  parameter logic [10:0] ID_MFR = 11'h2a5,    // arbitrary value
  parameter logic [sbt_pkg::BSR_W-1:0] NC_MASK = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // test port pins
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_tms_driven,
  input wire logic i_tdi_driven,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  // package pads
  input wire logic [sbt_pkg::BSR_W-1:0] i_pad_state,
  output logic [sbt_pkg::BSR_W-1:0] o_bsr_update,
  output logic o_dq_hiz,
  output logic o_extest
);
  import sbt_pkg::*;

  logic [PIN_W-1:0] pin_s;
  logic [BSR_W-1:0] pad_s;
  logic tck_s;
  logic tms_v;
  logic tdi_v;
  logic tck_prev_q;
  logic rise;
  logic fall;
  sbt_state_t state_q;
  sbt_state_t state_d;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_sh_q;
  logic bypass_q;
  logic [ID_W-1:0] id_q;
  logic [BSR_W-1:0] bsr_q;
  logic [ID_W-1:0] id_value;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;

  function automatic logic is_bypass(input logic [IR_W-1:0] code);
    is_bypass = (code == INS_BYPASS_A) || (code == INS_BYPASS_B) ||
                (code == INS_BYPASS_C) || (code == INS_RESERVED);
  endfunction : is_bypass

  sbt_sync #(.W(PIN_W)) u_pin_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d({i_tdi_driven, i_tms_driven, i_tdi, i_tms, i_tck}),
    .o_q(pin_s)
  );

  sbt_sync #(.W(BSR_W)) u_pad_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d(i_pad_state),
    .o_q(pad_s)
  );

  assign tck_s = pin_s[0];
  assign tms_v = pin_s[1] | ~pin_s[3];
  assign tdi_v = pin_s[2] | ~pin_s[4];
  assign rise = tck_s & ~tck_prev_q;
  assign fall = ~tck_s & tck_prev_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tck_prev_q <= 1'h0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  // controller next state
  always_comb begin
    case (state_q)
      ST_RESET:    state_d = tms_v ? ST_RESET : ST_IDLE;
      ST_IDLE:     state_d = tms_v ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   state_d = tms_v ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   state_d = tms_v ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms_v ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms_v ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms_v ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms_v ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   state_d = tms_v ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   state_d = tms_v ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   state_d = tms_v ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms_v ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms_v ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms_v ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms_v ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   state_d = tms_v ? ST_SEL_DR : ST_IDLE;
      default:     state_d = ST_RESET;
    endcase
  end

  // power-up reset stands in for a test reset pin
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= ST_RESET;
    end else if (rise) begin
      state_q <= state_d;
    end
  end

  // instruction shift and hold
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ir_q <= IR_RESET_VAL;
      ir_sh_q <= IR_CAPTURE_VAL;
    end else if (rise) begin
      case (state_q)
        ST_RESET:    ir_q <= IR_RESET_VAL;
        ST_CAP_IR:   ir_sh_q <= IR_CAPTURE_VAL;
        ST_SHIFT_IR: ir_sh_q <= {tdi_v, ir_sh_q[IR_W-1:1]};
        ST_UPD_IR:   ir_q <= ir_sh_q;
        default:     ir_q <= ir_q;
      endcase
    end
  end

  // reserved code falls back to bypass
  assign sel_bsr = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLEZ) ||
                   (ir_q == INS_SAMPLE);
  assign sel_id = (ir_q == INS_IDCODE);
  assign sel_byp = is_bypass(ir_q);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bypass_q <= BYPASS_RESET_VAL;
    end else if (rise) begin
      if (state_q == ST_UPD_IR && is_bypass(ir_sh_q)) begin
        bypass_q <= 1'h0;
      end else if (state_q == ST_CAP_DR && sel_byp) begin
        bypass_q <= 1'h0;
      end else if (state_q == ST_SHIFT_DR && sel_byp) begin
        bypass_q <= tdi_v;
      end
    end
  end

  assign id_value = {ID_REV, ID_PART, ID_VEND, ID_MFR, ID_START_BIT};

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      id_q <= '0;
    end else if (rise && sel_id) begin
      if (state_q == ST_CAP_DR) begin
        id_q <= id_value;
      end else if (state_q == ST_SHIFT_DR) begin
        id_q <= {tdi_v, id_q[ID_W-1:1]};
      end
    end
  end

  // chain sees pads only, never the array
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bsr_q <= '0;
      o_bsr_update <= '0;
    end else if (rise && sel_bsr) begin
      if (state_q == ST_CAP_DR) begin
        bsr_q <= pad_s & ~NC_MASK;
      end else if (state_q == ST_SHIFT_DR) begin
        bsr_q <= {tdi_v, bsr_q[BSR_W-1:1]};
      end else if (state_q == ST_UPD_DR) begin
        o_bsr_update <= bsr_q;
      end
    end
  end

  // data pin control from the held instruction
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_dq_hiz <= 1'h0;
      o_extest <= 1'h0;
    end else begin
      o_dq_hiz <= (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLEZ);
      o_extest <= (ir_q == INS_EXTEST);
    end
  end

  // serial out moves only on falling test clock
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_tdo <= 1'h0;
      o_tdo_oe_n <= 1'h1;
    end else if (fall) begin
      if (state_q == ST_SHIFT_IR) begin
        o_tdo <= ir_sh_q[0];
        o_tdo_oe_n <= 1'h0;
      end else if (state_q == ST_SHIFT_DR) begin
        o_tdo_oe_n <= 1'h0;
        if (sel_bsr) begin
          o_tdo <= bsr_q[0];
        end else if (sel_id) begin
          o_tdo <= id_q[0];
        end else begin
          o_tdo <= bypass_q;
        end
      end else begin
        o_tdo_oe_n <= 1'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_dr_shift_rise;
    rise && (state_q == ST_SHIFT_DR);
  endsequence

  sequence s_upd_ir_bypass;
    rise && (state_q == ST_UPD_IR) && is_bypass(ir_sh_q);
  endsequence

  sequence s_dr_shift_fall;
    fall && (state_q == ST_SHIFT_DR);
  endsequence

  a_fsm_one_hot: assert property ($onehot(state_q))
    else $error("controller state not one-hot");

  a_reset_state: assert property ($rose(i_reset_n) |-> state_q == ST_RESET)
    else $error("controller not in reset state after power-up");

  a_tdo_falling_only: assert property ($changed(o_tdo) |-> $past(fall))
    else $error("serial out changed without falling test clock");

  a_tdo_hiz_idle: assert property (fall && state_q != ST_SHIFT_IR &&
      state_q != ST_SHIFT_DR |=> o_tdo_oe_n)
    else $error("serial out driven outside shift states");

  a_reset_idcode: assert property (rise && state_q == ST_RESET |=> ir_q == INS_IDCODE)
    else $error("reset state did not load identification instruction");

  a_bypass_clear: assert property (s_upd_ir_bypass |=> !bypass_q && is_bypass(ir_q))
    else $error("bypass bit not cleared on bypass instruction");

  a_bypass_keep: assert property (s_dr_shift_rise ##0 sel_byp |=>
      bypass_q == $past(tdi_v))
    else $error("bypass bit lost the shifted value");

  a_bsr_shift_in: assert property (s_dr_shift_rise ##0 sel_bsr |=>
      bsr_q[BSR_W-1] == $past(tdi_v) && bsr_q[BSR_W-2:0] == $past(bsr_q[BSR_W-1:1]))
    else $error("boundary chain shift direction wrong");

  a_id_capture: assert property (rise && state_q == ST_CAP_DR && sel_id |=>
      id_q[0] && id_q[ID_W-1:ID_REV_LSB] == ID_REV)
    else $error("identification capture wrong");

  a_samplez_hiz: assert property (ir_q == INS_SAMPLEZ |=> o_dq_hiz)
    else $error("data pins not off under sample-with-outputs-off");

  a_sample_drive: assert property (ir_q == INS_SAMPLE |=> !o_dq_hiz && !o_extest)
    else $error("sample disturbed data pin drive");

  a_extest_hiz: assert property (ir_q == INS_EXTEST |=> o_dq_hiz && o_extest)
    else $error("external test did not turn data pins off");

  a_state_hold: assert property (!rise |=> $stable(state_q))
    else $error("controller state moved without rising test clock");

  a_ir_capture: assert property (rise && state_q == ST_CAP_IR |=>
      ir_sh_q == IR_CAPTURE_VAL)
    else $error("instruction capture pattern wrong");

  a_ir_update: assert property (rise && state_q == ST_UPD_IR |=>
      ir_q == $past(ir_sh_q))
    else $error("instruction not taken at update");

  a_tdo_shift_drive: assert property (s_dr_shift_fall |=> !o_tdo_oe_n)
    else $error("serial out not driven in data shift");

  a_tdo_ir_bit: assert property (fall && state_q == ST_SHIFT_IR |=>
      o_tdo == $past(ir_sh_q[0]) && !o_tdo_oe_n)
    else $error("instruction shift bit not driven on serial out");

  a_tdo_bypass_bit: assert property (s_dr_shift_fall ##0 sel_byp |=>
      o_tdo == $past(bypass_q))
    else $error("bypass bit not driven on serial out");

  a_tdo_id_bit: assert property (s_dr_shift_fall ##0 sel_id |=>
      o_tdo == $past(id_q[0]))
    else $error("identification bit not driven on serial out");

  a_bsr_capture: assert property (rise && state_q == ST_CAP_DR && sel_bsr |=>
      bsr_q == ($past(pad_s) & ~NC_MASK))
    else $error("boundary chain capture not from pads");

  a_bsr_update: assert property (rise && state_q == ST_UPD_DR && sel_bsr |=>
      o_bsr_update == $past(bsr_q))
    else $error("boundary update register not loaded");

  a_id_shift: assert property (s_dr_shift_rise ##0 sel_id |=>
      id_q == {$past(tdi_v), $past(id_q[ID_W-1:1])})
    else $error("identification shift wrong");

endmodule : sbt_tap

// File: include/sbt_pkg.sv
package sbt_pkg;

  // register lengths
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 107;
  localparam int PIN_W = 5;

  // instruction codes
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_BYPASS_A = 3'h3;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_RESERVED = 3'h5;
  localparam logic [2:0] INS_BYPASS_B = 3'h6;
  localparam logic [2:0] INS_BYPASS_C = 3'h7;

  // values after reset and on capture
  localparam logic [2:0] IR_RESET_VAL = INS_IDCODE;
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic BYPASS_RESET_VAL = 1'h0;

  // identification field positions
  localparam int ID_REV_LSB = 28;
  localparam int ID_PART_LSB = 18;
  localparam int ID_VEND_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic ID_START_BIT = 1'h1;

  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET     = 16'h0001,
    ST_IDLE      = 16'h0002,
    ST_SEL_DR    = 16'h0004,
    ST_CAP_DR    = 16'h0008,
    ST_SHIFT_DR  = 16'h0010,
    ST_EXIT1_DR  = 16'h0020,
    ST_PAUSE_DR  = 16'h0040,
    ST_EXIT2_DR  = 16'h0080,
    ST_UPD_DR    = 16'h0100,
    ST_SEL_IR    = 16'h0200,
    ST_CAP_IR    = 16'h0400,
    ST_SHIFT_IR  = 16'h0800,
    ST_EXIT1_IR  = 16'h1000,
    ST_PAUSE_IR  = 16'h2000,
    ST_EXIT2_IR  = 16'h4000,
    ST_UPD_IR    = 16'h8000
  } sbt_state_t;

endpackage : sbt_pkg

// File: src/sbt_sync.sv
module sbt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule : sbt_sync

// File: test/sbt_ctl_model.sv
module sbt_ctl_model (
  // clock
  input wire logic i_clk,
  // serial out of the port
  input wire logic i_tdo,
  // test port drive
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbt_pkg::*;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // one 400 ns test clock period; serial out read just before the rise
  task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo);
    @(negedge i_clk);
    o_tck = 1'b0;
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clk);
    tdo = i_tdo;
    o_tck = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask : tck_cycle

  task automatic go_idle();
    logic t;
    repeat (5) tck_cycle(1'b1, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
  endtask : go_idle

  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic t;
    cap = '0;
    if (code == INS_RESERVED) return;
    tck_cycle(1'b1, 1'b1, t);
    tck_cycle(1'b1, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
    for (int i = 0; i < 3; i++) tck_cycle(i == 2, code[i], cap[i]);
    tck_cycle(1'b1, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
  endtask : load_ir

  task automatic shift_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic t;
    dout = '0;
    tck_cycle(1'b1, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) tck_cycle(i == n - 1, din[i], dout[i]);
    tck_cycle(1'b1, 1'b1, t);
    tck_cycle(1'b0, 1'b1, t);
  endtask : shift_dr
endmodule : sbt_ctl_model

// File: test/sbt_tap_tb.sv
module sbt_tap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbt_pkg::*;

  // arbitrary values
  localparam logic [3:0] T_REV = 4'h9;
  localparam logic [9:0] T_PART = 10'h2c9;
  localparam logic [5:0] T_VEND = 6'h15;
  localparam logic [10:0] T_MFR = 11'h123;
  localparam logic [ID_W-1:0] EXP_ID = {T_REV, T_PART, T_VEND, T_MFR, ID_START_BIT};
  localparam logic [BSR_W-1:0] PAD_P = {11'h4b3, {12{8'h96}}};

  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic tms_drv = 1'b1;
  logic tdi_drv = 1'b1;
  logic [BSR_W-1:0] pad = PAD_P;
  logic tck, tms, tdi, tdo, tdo_oe_n, dq_hiz, extest;
  logic [BSR_W-1:0] bsr_upd;
  int err_count = 0;
  int check_count = 0;

  always #25 i_clk = ~i_clk;

  sbt_tap #(.ID_REV(T_REV), .ID_PART(T_PART), .ID_VEND(T_VEND), .ID_MFR(T_MFR)) sbt_tap_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_tms_driven(tms_drv), .i_tdi_driven(tdi_drv), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
    .i_pad_state(pad), .o_bsr_update(bsr_upd), .o_dq_hiz(dq_hiz), .o_extest(extest)
  );

  sbt_ctl_model sbt_ctl_model_inst (
    .i_clk(i_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi)
  );

  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic s_id_after_reset();
    logic [127:0] d;
    sbt_ctl_model_inst.go_idle();
    check_val(128'(tdo_oe_n), 128'h1);
    sbt_ctl_model_inst.shift_dr(64, 128'hc3a50f69, d);
    check_val(128'(d[31:0]), 128'(EXP_ID));
    check_val(128'(d[63:32]), 128'hc3a50f69);
  endtask : s_id_after_reset

  task automatic s_chain(input logic [2:0] code, input logic hiz, input logic ext,
                         input logic [BSR_W-1:0] p);
    logic [127:0] d;
    logic [2:0] cap;
    logic [BSR_W-1:0] np;
    np = ~p;
    @(negedge i_clk) pad = p;
    sbt_ctl_model_inst.load_ir(code, cap);
    check_val(128'(cap), 128'(IR_CAPTURE_VAL));
    // pin control follows the new instruction one clock later
    repeat (2) @(negedge i_clk);
    check_val(128'({dq_hiz, extest}), 128'({hiz, ext}));
    sbt_ctl_model_inst.shift_dr(BSR_W, 128'(np), d);
    check_val(128'(d[BSR_W-1:0]), 128'(p));
    check_val(128'(bsr_upd), 128'(np));
  endtask : s_chain

  task automatic s_bypass(input logic [2:0] code);
    logic [127:0] d;
    logic [2:0] cap;
    sbt_ctl_model_inst.load_ir(code, cap);
    sbt_ctl_model_inst.shift_dr(8, 128'h5c, d);
    check_val(128'(d[7:0]), 128'hb8);
  endtask : s_bypass

  task automatic s_undriven();
    logic [127:0] d;
    logic [2:0] cap;
    logic t;
    sbt_ctl_model_inst.load_ir(INS_BYPASS_A, cap);
    @(negedge i_clk) tdi_drv = 1'b0;
    sbt_ctl_model_inst.shift_dr(8, 128'h0, d);
    check_val(128'(d[7:0]), 128'hfe);
    @(negedge i_clk) tdi_drv = 1'b1;
    tms_drv = 1'b0;
    repeat (5) sbt_ctl_model_inst.tck_cycle(1'b0, 1'b1, t);
    @(negedge i_clk) tms_drv = 1'b1;
    sbt_ctl_model_inst.tck_cycle(1'b0, 1'b1, t);
    sbt_ctl_model_inst.shift_dr(32, 128'h0, d);
    check_val(128'(d[31:0]), 128'(EXP_ID));
  endtask : s_undriven

  // hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (12) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    s_id_after_reset();
    s_chain(INS_EXTEST, 1'b1, 1'b1, PAD_P);
    s_chain(INS_SAMPLEZ, 1'b1, 1'b0, ~PAD_P);
    s_chain(INS_SAMPLE, 1'b0, 1'b0, {PAD_P[0], PAD_P[BSR_W-1:1]});
    s_bypass(INS_BYPASS_A);
    s_bypass(INS_BYPASS_B);
    s_bypass(INS_BYPASS_C);
    s_undriven();
    print_verdict();
  end
endmodule : sbt_tap_tb
